//--- mviu_consts.svh
// What this block does
// - Accept nine requests from five source groups.
// - Port 5 pin differing from reference raises change.
// - Enabled port change wakes device from sleep.
// - Wake continues inline; if enabled, vector 006H.
// - External pulses under 8 clocks are rejected.
// - Low-frequency crystal mode bypasses the filter.
// - Edge-select bit picks the active external edge.
// - External interrupt vectors to 003H.
// - Enable instruction sets, disable clears global enable.
// - Flags except port change set regardless of enable.
// - Primary status read returns flags ANDed with mask.
// - Return instruction ends routine, sets global enable.
// - Timers vector to 009H, 018H, 01BH, 01EH.
// - ADC completion vectors to 00CH.
// - High/low pulse underflows vector to 012H, 015H.
// - Save accumulator, status, select on entry; restore after.
// - Single shadow copy, overwritten by later interrupts.
// - Priority: ext, change, main, ADC, high, low, A, B, C.
`ifndef MVIU_CONSTS_SVH
`define MVIU_CONSTS_SVH

// Source indices, which are also the priority order, 0 being highest.
`define MVIU_SRC_EXT 0
`define MVIU_SRC_CHG 1
`define MVIU_SRC_MAIN 2
`define MVIU_SRC_ADC 3
`define MVIU_SRC_HIGH 4
`define MVIU_SRC_LOW 5
`define MVIU_SRC_TA 6
`define MVIU_SRC_TB 7
`define MVIU_SRC_TC 8
`define MVIU_NSRC 9

// Vector addresses in source order.
`define MVIU_VEC_EXT 10'h003
`define MVIU_VEC_CHG 10'h006
`define MVIU_VEC_MAIN 10'h009
`define MVIU_VEC_ADC 10'h00C
`define MVIU_VEC_HIGH 10'h012
`define MVIU_VEC_LOW 10'h015
`define MVIU_VEC_TA 10'h018
`define MVIU_VEC_TB 10'h01B
`define MVIU_VEC_TC 10'h01E

// Noise filter: a level must hold this many clocks to be accepted.
`define MVIU_FILT_CYCLES 4'h8
`define MVIU_FILT_ZERO 4'h0
`define MVIU_FILT_ONE 4'h1

// Reset values.
`define MVIU_FLAGS_RST 9'h000
`define MVIU_BYTE_RST 8'h00
`define MVIU_PORT_RST 8'h00

`endif

//--- mviu_pkg.sv
package mviu_pkg;

    // Core-visible registers saved on interrupt entry.
    typedef struct packed {
        logic [7:0] accumulator;
        logic [7:0] status_register;
        logic [7:0] file_select_register;
    } mviu_ctx_type;

    // Per-source event strobes from the timers, ADC and pulse generator.
    typedef struct packed {
        logic timer_c;
        logic timer_b;
        logic timer_a;
        logic low_time;
        logic high_time;
        logic adc_done;
        logic main_timer;
    } mviu_evt_type;

    // Instruction strobes from the decoder.
    typedef struct packed {
        logic enable_irq_instr;
        logic disable_irq_instr;
        logic return_from_irq_instr;
        logic sleep_instr;
        logic port5_read;
    } mviu_instr_type;

    // Sequencer state.
    typedef enum logic [1:0] {
        MVIU_RUN,
        MVIU_SLEEP,
        MVIU_SERVICE
    } mviu_state_type;

    // Whole state of the filter module.
    typedef struct packed {
        logic [3:0] count;
        logic level;
        logic prev;
        logic edge_seen;
    } mviu_filt_type;

    // Whole state of the top module.
    typedef struct packed {
        mviu_state_type state;
        logic gie;
        logic [8:0] flags;
        logic [7:0] port_ref;
        logic chg_en_at_sleep;
        mviu_ctx_type shadow;
        logic [9:0] vector;
        logic vector_valid;
        logic restore_valid;
        logic wake;
    } mviu_top_type;

endpackage : mviu_pkg

//--- mviu_ext_filter.sv
`timescale 1ns/1ps
`include "mviu_consts.svh"

// External pin conditioner: noise rejection, edge select, one-cycle edge strobe.
module mviu_ext_filter
    import mviu_pkg::*;
(
    input wire logic clock, // System clock.
    input wire logic arst_n, // Asynchronous active-low reset.
    input wire logic clk_en, // Freezes all state while low.
    input wire logic pin_sync, // Already synchronised pin level.
    input wire logic bypass, // High to skip noise rejection.
    input wire logic edge_rising, // High selects the rising edge.
    output logic edge_pulse // One-cycle pulse on an accepted edge.
);

    mviu_filt_type s_q; // Registered state.
    mviu_filt_type s_d; // Next state.
    logic filtered; // Level after optional filter.

    // The filter accepts a new level only once it has stood 8 clocks.
    always_comb begin
        s_d = s_q;
        if (pin_sync == s_q.level) begin
            s_d.count = `MVIU_FILT_ZERO;
        end else if (s_q.count == `MVIU_FILT_CYCLES - `MVIU_FILT_ONE) begin
            s_d.level = pin_sync;
            s_d.count = `MVIU_FILT_ZERO;
        end else begin
            s_d.count = s_q.count + `MVIU_FILT_ONE;
        end
        filtered = bypass ? pin_sync : s_q.level;
        s_d.prev = filtered;
        // Edge polarity follows the select bit.
        s_d.edge_seen = edge_rising ? (filtered & ~s_q.prev)
                                    : (~filtered & s_q.prev);
    end

    // Registered state; edge_pulse is a flop output ANDed with clk_en.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign edge_pulse = s_q.edge_seen & clk_en;

endmodule : mviu_ext_filter

//--- mviu_vectored_interrupt_unit.sv
`timescale 1ns/1ps
`include "mviu_consts.svh"

// Vectored interrupt unit: flags, masks, priority, vectors, context shadow.
module mviu_vectored_interrupt_unit
    import mviu_pkg::*;
(
    input wire logic clock, // System clock, 200 MHz.
    input wire logic arst_n, // Asynchronous active-low reset.
    input wire logic clk_en, // Freezes all state while low.
    input wire logic ext_pin, // External interrupt pin, asynchronous.
    input wire logic [7:0] port5_pins, // Port 5 pin levels, asynchronous.
    input wire logic ext_edge_select, // 1 rising, 0 falling.
    input wire logic low_freq_crystal_mode, // Bypasses the noise filter.
    input mviu_evt_type events, // One-cycle source events.
    input mviu_instr_type instr, // One-cycle instruction strobes.
    input wire logic [8:0] irq_mask_reg, // Mask per source, source order.
    input wire logic [8:0] flag_clear, // Software clears, one per source.
    input mviu_ctx_type ctx_now, // Live core registers.
    input wire logic ack, // Core has taken the vector.
    output logic [8:0] irq_flags, // Raw flags.
    output logic [8:0] irq_flag_read, // Flags ANDed with mask.
    output logic [7:0] port5_ref, // Reference value for change detection.
    output logic global_enable, // Global interrupt enable.
    output logic sleeping, // Device is asleep.
    output logic wake, // One-cycle wake pulse.
    output logic vector_valid, // Vector request to the core.
    output logic [9:0] vector_addr, // Fetch address for the vector.
    output mviu_ctx_type ctx_restore, // Context to restore.
    output logic restore_valid // One-cycle restore strobe.
);

    // Two-flop synchronisers; first stage read only by second stage.
    logic ext_s1_q;
    logic ext_s2_q;
    logic [7:0] p5_s1_q;
    logic [7:0] p5_s2_q;
    logic ext_edge; // Accepted external edge.
    logic [8:0] evt_set; // Per-source set requests.
    logic [8:0] pending; // Flags that are masked in.
    logic [9:0] vec_table [`MVIU_NSRC]; // Vector per source.
    logic [`MVIU_NSRC-1:0] win; // One-hot winner.
    logic [9:0] win_vec; // Winner's vector.
    mviu_top_type s_q; // Registered state.
    mviu_top_type s_d; // Next state.

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ext_s1_q <= 1'h0;
            ext_s2_q <= 1'h0;
            p5_s1_q <= `MVIU_PORT_RST;
            p5_s2_q <= `MVIU_PORT_RST;
        end else if (clk_en) begin
            ext_s1_q <= ext_pin;
            ext_s2_q <= ext_s1_q;
            p5_s1_q <= port5_pins;
            p5_s2_q <= p5_s1_q;
        end
    end

    // Noise filter and edge select live in their own module.
    mviu_ext_filter u_filt (
        .clock(clock),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .pin_sync(ext_s2_q),
        .bypass(low_freq_crystal_mode),
        .edge_rising(ext_edge_select),
        .edge_pulse(ext_edge)
    );

    // Gather the nine sources in priority order.
    always_comb begin
        evt_set = '0;
        evt_set[`MVIU_SRC_EXT] = ext_edge;
        evt_set[`MVIU_SRC_CHG] = |(p5_s2_q ^ s_q.port_ref)
                                 & irq_mask_reg[`MVIU_SRC_CHG];
        evt_set[`MVIU_SRC_MAIN] = events.main_timer;
        evt_set[`MVIU_SRC_ADC] = events.adc_done;
        evt_set[`MVIU_SRC_HIGH] = events.high_time;
        evt_set[`MVIU_SRC_LOW] = events.low_time;
        evt_set[`MVIU_SRC_TA] = events.timer_a;
        evt_set[`MVIU_SRC_TB] = events.timer_b;
        evt_set[`MVIU_SRC_TC] = events.timer_c;
    end

    assign vec_table[`MVIU_SRC_EXT] = `MVIU_VEC_EXT;
    assign vec_table[`MVIU_SRC_CHG] = `MVIU_VEC_CHG;
    assign vec_table[`MVIU_SRC_MAIN] = `MVIU_VEC_MAIN;
    assign vec_table[`MVIU_SRC_ADC] = `MVIU_VEC_ADC;
    assign vec_table[`MVIU_SRC_HIGH] = `MVIU_VEC_HIGH;
    assign vec_table[`MVIU_SRC_LOW] = `MVIU_VEC_LOW;
    assign vec_table[`MVIU_SRC_TA] = `MVIU_VEC_TA;
    assign vec_table[`MVIU_SRC_TB] = `MVIU_VEC_TB;
    assign vec_table[`MVIU_SRC_TC] = `MVIU_VEC_TC;

    assign pending = s_q.flags & irq_mask_reg;

    // Fixed priority: a source wins when no lower index is pending.
    genvar gi;
    generate
        for (gi = 0; gi < `MVIU_NSRC; gi++) begin : g_prio
            if (gi == 0) begin : g_first
                assign win[gi] = pending[gi];
            end else begin : g_rest
                assign win[gi] = pending[gi] & ~|pending[gi-1:0];
            end
        end
    endgenerate

    // Select the winner's vector from the one-hot.
    always_comb begin
        win_vec = '0;
        for (int i = 0; i < `MVIU_NSRC; i++) begin
            win_vec = win_vec | (vec_table[i] & {10{win[i]}});
        end
    end

    // Next-state logic: flags, enable, sleep, vector and shadow.
    always_comb begin
        s_d = s_q;
        s_d.wake = 1'h0;
        s_d.restore_valid = 1'h0;
        // Set beats clear in the same cycle; flags ignore global enable.
        s_d.flags = (s_q.flags & ~flag_clear) | evt_set;
        // Reading port 5 refreshes the change reference.
        if (instr.port5_read) begin
            s_d.port_ref = p5_s2_q;
        end
        if (instr.enable_irq_instr) begin
            s_d.gie = 1'h1;
        end else if (instr.disable_irq_instr) begin
            s_d.gie = 1'h0;
        end
        unique case (s_q.state)
            MVIU_RUN: begin
                if (instr.sleep_instr) begin
                    s_d.state = MVIU_SLEEP;
                    s_d.chg_en_at_sleep = irq_mask_reg[`MVIU_SRC_CHG];
                end else if (s_q.gie && (|pending)) begin
                    // Take the vector and save context in one step.
                    s_d.state = MVIU_SERVICE;
                    s_d.gie = 1'h0;
                    s_d.vector = win_vec;
                    s_d.vector_valid = 1'h1;
                    s_d.shadow = ctx_now;
                end
            end
            MVIU_SLEEP: begin
                // Only a change enabled before sleeping can wake.
                if (s_q.chg_en_at_sleep && evt_set[`MVIU_SRC_CHG]) begin
                    s_d.state = MVIU_RUN;
                    s_d.wake = 1'h1;
                end
            end
            MVIU_SERVICE: begin
                if (ack) begin
                    s_d.vector_valid = 1'h0;
                end
                // A nested request while enabled overwrites the shadow.
                if (s_q.gie && (|pending) && !s_q.vector_valid) begin
                    s_d.gie = 1'h0;
                    s_d.vector = win_vec;
                    s_d.vector_valid = 1'h1;
                    s_d.shadow = ctx_now;
                end else if (instr.return_from_irq_instr) begin
                    s_d.state = MVIU_RUN;
                    s_d.gie = 1'h1;
                    s_d.restore_valid = 1'h1;
                end
            end
        endcase
    end

    // One register for the whole state.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign irq_flags = s_q.flags;
    assign irq_flag_read = s_q.flags & irq_mask_reg;
    assign port5_ref = s_q.port_ref;
    assign global_enable = s_q.gie;
    assign sleeping = (s_q.state == MVIU_SLEEP);
    assign wake = s_q.wake;
    assign vector_valid = s_q.vector_valid;
    assign vector_addr = s_q.vector;
    assign ctx_restore = s_q.shadow;
    assign restore_valid = s_q.restore_valid;

endmodule : mviu_vectored_interrupt_unit

//--- mviu_chk_assertions.sv
`timescale 1ns/1ps
// Watches the unit's ports and ties the flag, enable, vector and shadow outputs to their causes.
module mviu_chk
    import mviu_pkg::*;
(
    input wire logic clock, // System clock.
    input wire logic arst_n, // Reset, active low.
    input wire logic clk_en, // Run enable.
    input mviu_evt_type events, // Source events.
    input mviu_instr_type instr, // Instruction strobes.
    input wire logic [8:0] irq_mask_reg, // Masks.
    input mviu_ctx_type ctx_now, // Live context.
    input wire logic ack, // Core accept.
    input wire logic [8:0] irq_flags, // Raw flags.
    input wire logic [8:0] irq_flag_read, // Masked flags.
    input wire logic global_enable, // Global enable.
    input wire logic wake, // Wake pulse.
    input wire logic vector_valid, // Vector request.
    input wire logic [9:0] vector_addr, // Vector.
    input mviu_ctx_type ctx_restore, // Shadow copy.
    input wire logic restore_valid // Restore strobe.
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    masked_read_a: assert property (irq_flag_read == (irq_flags & irq_mask_reg))
        else $error("masked flag read wrong");
    vec_takes_gie_a: assert property ($rose(vector_valid) |->
        $past(global_enable) && !global_enable)
        else $error("vector without enable or enable kept");
    vec_holds_a: assert property (vector_valid && !ack |=>
        vector_valid && $stable(vector_addr))
        else $error("vector dropped before accept");
    vec_table_a: assert property (vector_valid |-> vector_addr inside {
        10'h003, 10'h006, 10'h009, 10'h00C, 10'h012, 10'h015, 10'h018, 10'h01B, 10'h01E})
        else $error("vector address not in table");
    ext_first_a: assert property ($rose(vector_valid) && $past(irq_flag_read[0]) |->
        vector_addr == 10'h003)
        else $error("external request lost priority");
    flag_sets_a: assert property (clk_en && events.adc_done |=> irq_flags[3])
        else $error("event flag not set");
    gie_on_a: assert property (clk_en && instr.enable_irq_instr && !global_enable |=>
        global_enable)
        else $error("enable instruction ignored");
    gie_off_a: assert property (clk_en && instr.disable_irq_instr && !instr.enable_irq_instr |=>
        !global_enable)
        else $error("disable instruction ignored");
    return_from_irq_instr_gie_a: assert property (clk_en && instr.return_from_irq_instr |=> global_enable)
        else $error("return did not enable");
    shadow_a: assert property ($rose(vector_valid) |-> ctx_restore == $past(ctx_now))
        else $error("context not saved on entry");
    vec_c: cover property ($rose(vector_valid));
    wake_c: cover property (wake);
    restore_c: cover property (restore_valid);
endmodule : mviu_chk

bind mviu_vectored_interrupt_unit mviu_chk u_chk (.clock, .arst_n, .clk_en, .events, .instr,
    .irq_mask_reg, .ctx_now, .ack, .irq_flags, .irq_flag_read, .global_enable, .wake,
    .vector_valid, .vector_addr, .ctx_restore, .restore_valid);

//--- mviu_core_model.sv
`timescale 1ns/1ps
// Core side: takes each vector after a chosen number of cycles.
module mviu_core_model (
    input wire logic clock, // System clock.
    input wire logic arst_n, // Reset, active low.
    input wire logic [3:0] delay, // Cycles before accepting.
    input wire logic vector_valid, // Vector request.
    input wire logic [9:0] vector_addr, // Vector.
    output logic ack, // Accept pulse.
    output logic [9:0] last_vec, // Last taken vector.
    output int n_vec // Vectors taken.
);
    int wait_q; // Cycles waited so far.
    // Driven off the falling edge so the unit samples a settled accept.
    always @(negedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ack <= 1'b0;
            wait_q <= 0;
            n_vec <= 0;
            last_vec <= 10'h000;
        end else if (ack) begin
            ack <= 1'b0;
        end else if (vector_valid && wait_q >= delay) begin
            ack <= 1'b1; // The fetch happens here.
            last_vec <= vector_addr;
            n_vec <= n_vec + 1;
            wait_q <= 0;
        end else if (vector_valid) begin
            wait_q <= wait_q + 1;
        end
    end
endmodule : mviu_core_model

//--- mviu_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the vectored interrupt unit.
module tb;
    import mviu_pkg::*;
    logic clock = 1'b0, arst_n = 1'b0, clk_en = 1'b1, ext_pin = 1'b0; // Clock, reset, pin.
    logic ext_edge_select = 1'b1, low_freq_crystal_mode = 1'b0; // Edge and bypass.
    logic [7:0] port5_pins = 8'h00; // Port 5 levels.
    mviu_evt_type events = 7'h00; // Events.
    mviu_instr_type instr = 5'h00; // Instruction strobes.
    logic [8:0] irq_mask_reg = 9'h000, flag_clear = 9'h000; // Masks and clears.
    mviu_ctx_type ctx_now = 24'h112233, ctx_prev; // Live and expected context.
    logic [3:0] delay = 4'h3; // Core response delay.
    logic ack, sleeping, wake, vector_valid, restore_valid, global_enable; // Outputs.
    logic [8:0] irq_flags, irq_flag_read; // Flags.
    logic [7:0] port5_ref; // Change reference.
    logic [9:0] vector_addr, last_vec; // Vectors.
    mviu_ctx_type ctx_restore; // Shadow.
    int n_vec, n_fail = 0, checked = 0, cycles = 0; // Counters.
    logic [9:0] vec_tab [7] = '{10'h009, 10'h00C, 10'h012, 10'h015, 10'h018, 10'h01B, 10'h01E};
    always #2.5 clock = ~clock;
    mviu_vectored_interrupt_unit uut (.clock, .arst_n, .clk_en, .ext_pin, .port5_pins,
        .ext_edge_select, .low_freq_crystal_mode, .events, .instr, .irq_mask_reg, .flag_clear,
        .ctx_now, .ack, .irq_flags, .irq_flag_read, .port5_ref, .global_enable, .sleeping,
        .wake, .vector_valid, .vector_addr, .ctx_restore, .restore_valid);
    mviu_core_model core (.clock, .arst_n, .delay, .vector_valid, .vector_addr, .ack,
        .last_vec, .n_vec);
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick
    // Bit order is enable, disable, return, sleep, port read.
    task automatic do_instr(input logic [4:0] which);
        instr = which;
        tick(1);
        instr = 5'h00;
        tick(1);
    endtask : do_instr
    // Waits for the core to take a vector, then clears the flag and returns.
    task automatic service(input logic [9:0] exp, input int src);
        int seen0;
        seen0 = n_vec;
        for (int i = 0; i < 80 && n_vec == seen0; i++) tick(1);
        check(n_vec, seen0 + 1);
        check(last_vec, exp);
        check(global_enable, 1'b0);
        check(ctx_restore, ctx_prev);
        ctx_now = ctx_now + 24'h010101;
        ctx_prev = ctx_now;
        flag_clear = 9'h001 << src;
        tick(1);
        flag_clear = 9'h000;
        instr = 5'h04;
        tick(1);
        instr = 5'h00;
        check(restore_valid, 1'b1);
        check(global_enable, 1'b1);
        tick(1);
    endtask : service
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up
    // A hang counts as a failure and still reaches the closing report.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            wrap_up();
        end
    end
    initial begin
        ctx_prev = ctx_now;
        tick(5);
        arst_n = 1'b1;
        tick(2);
        check(irq_flags, 9'h000);
        check(global_enable, 1'b0);
        $display("test reset done");
        // Flags rise with interrupts off, and reads are masked.
        irq_mask_reg = 9'h004;
        events = 7'h7F;
        tick(1);
        events = 7'h00;
        tick(1);
        check(irq_flags, 9'h1FC);
        check(irq_flag_read, 9'h004);
        check(vector_valid, 1'b0);
        $display("test flags done");
        // All seven pending are taken one at a time in priority order.
        irq_mask_reg = 9'h1FF;
        do_instr(5'h10);
        foreach (vec_tab[i]) service(vec_tab[i], i + 2);
        check(irq_flags, 9'h000);
        $display("test priority done");
        // A seven-cycle pulse is noise; a held level is taken promptly.
        delay = 4'h0;
        ext_pin = 1'b1;
        tick(7);
        ext_pin = 1'b0;
        tick(20);
        check(irq_flags[0], 1'b0);
        ext_pin = 1'b1;
        service(10'h003, 0);
        low_freq_crystal_mode = 1'b1;
        ext_edge_select = 1'b0;
        ext_pin = 1'b0;
        tick(2);
        ext_pin = 1'b1;
        service(10'h003, 0);
        tick(10);
        check(irq_flags[0], 1'b0);
        $display("test external done");
        // Change wakes the core; with interrupts off it runs on inline.
        do_instr(5'h08);
        irq_mask_reg = 9'h1FD;
        port5_pins = 8'h5A;
        tick(3);
        do_instr(5'h01);
        irq_mask_reg = 9'h1FF;
        check(port5_ref, 8'h5A);
        do_instr(5'h02);
        check(sleeping, 1'b1);
        port5_pins = 8'h52;
        for (int i = 0; i < 20 && wake !== 1'b1; i++) tick(1);
        check(wake, 1'b1);
        tick(1);
        check(sleeping, 1'b0);
        check(vector_valid, 1'b0);
        do_instr(5'h01);
        do_instr(5'h10);
        service(10'h006, 1);
        $display("test port change done");
        // With the clock enable low an event must leave every flag alone.
        clk_en = 1'b0;
        events = 7'h01;
        tick(1);
        events = 7'h00;
        clk_en = 1'b1;
        tick(1);
        check(irq_flags, 9'h000);
        $display("test clock enable done");
        wrap_up();
    end
endmodule : tb
